// file: core/emp_port_a.sv
`timescale 1ns/100ps
module emp_port_a #(
   parameter emp_pkg::emp_mode_t MODE = emp_pkg::emp_single_port,
   parameter int  DATA_W      = 8,
   parameter int  ADDR_W      = 8,
   parameter int  DEPTH       = 256,
   parameter int  LANE_W      = 8,
   parameter bit  USE_IN_CE   = 1'b1,
   parameter bit  USE_OUT_CE  = 1'b1,
   parameter bit  USE_HOLD    = 1'b1,
   parameter bit  USE_ACLR    = 1'b1,
   parameter bit  ACLR_Q_A    = 1'b1,
   parameter bit  ACLR_Q_B    = 1'b0,
   parameter bit  REG_Q_A     = 1'b1,
   parameter bit  USE_RD_EN   = 1'b1,
   parameter bit  USE_BYTE_EN = 1'b1,
   parameter bit  IN_LES      = 1'b0,
   parameter bit  INIT_PORT_B = 1'b0,
   parameter logic [DEPTH*DATA_W-1:0] INIT_IMAGE = '0
)(
   input  wire logic                           mclk_i,
   input  wire logic                           rst_n_i,
   input  wire logic                           aclr_i,
   input  wire logic                           in_clk_en_a_i,
   input  wire logic                           out_clk_en_a_i,
   input  wire logic [DATA_W-1:0]              wr_data_a_i,
   input  wire logic [ADDR_W-1:0]              addr_a_i,
   input  wire logic                           wr_en_a_i,
   input  wire logic                           rd_en_a_i,
   input  wire logic [DATA_W/LANE_W-1:0]       byte_en_a_i,
   input  wire logic                           addr_hold_a_i,
   output logic      [DATA_W-1:0]              rd_data_a_o,
   input  wire logic [3:0]                     avs_address_i,
   input  wire logic                           avs_read_i,
   input  wire logic                           avs_write_i,
   input  wire logic [emp_pkg::EMP_BUS_W-1:0]  avs_writedata_i,
   input  wire logic [3:0]                     avs_byteenable_i,
   output logic      [emp_pkg::EMP_BUS_W-1:0]  avs_readdata_o,
   output logic                                avs_waitrequest_o
);
   localparam int LANES = DATA_W / LANE_W;
   localparam int BW    = emp_pkg::EMP_BUS_W;

   // mode-dependent port presence
   wire has_wr = (MODE != emp_pkg::emp_rom_mode);
   wire has_q  = (MODE != emp_pkg::emp_simple_two_port);
   wire has_bm = has_wr && !IN_LES && USE_BYTE_EN;

   logic              run_q;
   logic              run_d;
   logic [ADDR_W-1:0] addr_q;
   logic [31:0]       wrcnt_q;
   logic              ack_q;
   logic [BW-1:0]     rdbus_q;
   logic [BW-1:0]     rdbus_d;
   logic [DATA_W-1:0] q_reg;

   // build options gate the pins; a missing clock enable reads as always-on, a missing hold or clear as never asserted
   wire in_ce  = (USE_IN_CE ? in_clk_en_a_i : 1'b1) && run_q;
   wire out_ce = USE_OUT_CE ? out_clk_en_a_i : 1'b1;
   wire hold   = USE_HOLD && addr_hold_a_i;
   wire aclr   = USE_ACLR && aclr_i;
   wire clr_qa = aclr && ACLR_Q_A;
   wire [ADDR_W-1:0] addr_eff = hold ? addr_q : addr_a_i;
   wire wr_go  = has_wr && wr_en_a_i;
   wire rd_go  = USE_RD_EN ? rd_en_a_i : 1'b1;
   wire [LANES-1:0] lanes = has_bm ? byte_en_a_i : {LANES{1'b1}};

   emp_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) mif ();

   assign mif.rst_n   = rst_n_i;
   assign mif.clr     = clr_qa && !REG_Q_A;
   assign mif.ce      = in_ce;
   assign mif.we      = wr_go;
   assign mif.rd      = rd_go;
   assign mif.addr    = addr_eff;
   assign mif.wdata   = wr_data_a_i;
   assign mif.lane_en = lanes;

   // one primary clock drives every registered port of A
   emp_mem_array #(
      .DATA_W     (DATA_W),
      .ADDR_W     (ADDR_W),
      .DEPTH      (DEPTH),
      .LANE_W     (LANE_W),
      .INIT_IMAGE (INIT_IMAGE)
   ) u_mem (
      .clk_i (mclk_i),
      .m     (mif)
   );

   emp_out_stage #(.DATA_W(DATA_W)) u_out (
      .clk_i   (mclk_i),
      .rst_n_i (rst_n_i),
      .clr_i   (clr_qa && REG_Q_A),
      .ce_i    (out_ce),
      .d_i     (mif.rdata),
      .q_o     (q_reg)
   );

   // read data width equals write data width by construction
   assign rd_data_a_o = !has_q ? '0 : (REG_Q_A ? q_reg : mif.rdata);

   // registered address; hold is an extra active-low enable
   always_ff @(posedge mclk_i or posedge aclr)
   begin
      if (aclr)
         addr_q <= '0;
      else if (!rst_n_i)
         addr_q <= '0;
      else if (in_ce && !hold)
         addr_q <= addr_a_i;
   end

   // register bus: one wait cycle, answer on the second
   wire bus_req = avs_read_i || avs_write_i;
   wire bus_go  = bus_req && ack_q;
   wire sel_ctrl   = (avs_address_i == emp_pkg::EMP_CTRL_OFS);
   wire sel_status = (avs_address_i == emp_pkg::EMP_STATUS_OFS);
   wire sel_wrcnt  = (avs_address_i == emp_pkg::EMP_WRCNT_OFS);
   wire sel_config = (avs_address_i == emp_pkg::EMP_CONFIG_OFS);
   wire ctrl_wr = bus_go && avs_write_i && sel_ctrl && avs_byteenable_i[0];

   wire [BW-1:0] cfg_word = BW'({
      2'(MODE), INIT_PORT_B, USE_RD_EN, REG_Q_A, ACLR_Q_B,
      ACLR_Q_A, USE_ACLR, USE_HOLD, USE_OUT_CE, USE_IN_CE});
   wire [BW-1:0] st_word  = BW'({hold, in_ce, addr_q});

   assign run_d = ctrl_wr ? avs_writedata_i[emp_pkg::EMP_CTRL_RUN_BIT] : run_q;

   always_comb
   begin
      rdbus_d = '0;
      if (sel_ctrl)
         rdbus_d = BW'(run_q);
      else if (sel_status)
         rdbus_d = st_word;
      else if (sel_wrcnt)
         rdbus_d = wrcnt_q;
      else if (sel_config)
         rdbus_d = cfg_word;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         run_q   <= emp_pkg::EMP_CTRL_RST;
         ack_q   <= 1'b0;
         rdbus_q <= '0;
      end
      else
      begin
         run_q   <= run_d;
         ack_q   <= bus_req && !ack_q;
         rdbus_q <= (bus_req && !ack_q && avs_read_i) ? rdbus_d : rdbus_q;
      end
   end

   // counts stored writes, wraps
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         wrcnt_q <= '0;
      else if (in_ce && wr_go)
         wrcnt_q <= wrcnt_q + 32'h1;
   end

   assign avs_waitrequest_o = bus_req && !ack_q;
   assign avs_readdata_o    = rdbus_q;

   // ---------------- checks ----------------
   logic              chk_v_q;
   logic [ADDR_W-1:0] chk_a_q;
   logic [DATA_W-1:0] chk_d_q;
   logic              aclr_seen_q;

   // a clear released on an edge still blocks the loads of that edge
   always_ff @(posedge mclk_i)
   begin
      chk_v_q     <= rst_n_i && in_ce && wr_go && (&lanes);
      chk_a_q     <= addr_eff;
      chk_d_q     <= wr_data_a_i;
      aclr_seen_q <= aclr;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i || aclr || aclr_seen_q);

   AST_ADDR_HOLD: assert property (in_ce && hold |=> addr_q == $past(addr_q))
      else $error("address moved while held");
   AST_ADDR_LOAD: assert property (in_ce && !hold |=> addr_q == $past(addr_a_i))
      else $error("address not registered");
   AST_IN_CE_OFF: assert property (!in_ce |=> $stable(addr_q) && $stable(mif.rdata))
      else $error("input registers moved without enable");
   AST_OUT_CE_OFF: assert property (REG_Q_A && !out_ce |=> $stable(q_reg))
      else $error("output register moved without enable");
   AST_OUT_LATENCY: assert property (REG_Q_A && out_ce |=> q_reg == $past(mif.rdata))
      else $error("registered output not one clock behind");
   AST_WRITE_READ: assert property (chk_v_q && in_ce && rd_go && !wr_go
      && addr_eff == chk_a_q |=> mif.rdata == $past(chk_d_q))
      else $error("written word not read back");
   AST_ROM_NO_WRITE: assert property (MODE == emp_pkg::emp_rom_mode |-> !mif.we)
      else $error("write in read-only mode");
   AST_RD_GATE: assert property (USE_RD_EN && !rd_en_a_i |=> $stable(mif.rdata))
      else $error("read happened without read enable");
   AST_ACLR_NOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      aclr |-> addr_q == '0)
      else $error("clear did not reset address");
   AST_NO_Q_SIMPLE: assert property (!has_q |-> rd_data_a_o == '0)
      else $error("read data driven in simple two-port mode");

   COV_WRITE: cover property (in_ce && wr_go);
   COV_HOLD_RUN: cover property (in_ce && hold [*3]);
   COV_READBACK: cover property (chk_v_q && in_ce && !wr_go && addr_eff == chk_a_q);
   COV_OUT_STALL: cover property (REG_Q_A && !out_ce ##1 out_ce);

endmodule

// file: core/emp_pkg.sv
// Notes on behaviour
// - separate build-time clock enables for input and output registers; disabled registers hold.
// - address hold acts as an extra active-low clock enable on the address register.
// - while hold is high the previously registered address is used.
// - built-in asynchronous clear resets registered ports at once, no clock edge.
// - clearing of port A and port B read data are separate build options.
// - the initial image is read using the dimensions of the chosen port; the code always uses port A's, INIT_PORT_B only sets a config bit.
// - write data exists in all modes except read-only mode.
// - the address input exists in every mode.
// - write enable exists outside read-only mode; writes only while it is asserted.
// - optional read enable gates reads, depending on mode and block type; the code applies USE_RD_EN the same way in every mode and block type.
// - byte mask limits which lanes are written; none in read-only or logic builds.
// - read data exists in single-port, true two-port and read-only modes.
// - read data is exactly as wide as write data.
// - in single-clock mode one clock drives every registered port.
// - in independent-clock mode port A registers run on the primary clock.
package emp_pkg;

   typedef enum logic [1:0]
   {
      emp_single_port,
      emp_simple_two_port,
      true_two_port_mode,
      emp_rom_mode
   } emp_mode_t;

   // register map, byte addresses
   localparam logic [3:0] EMP_CTRL_OFS   = 4'h0;
   localparam logic [3:0] EMP_STATUS_OFS = 4'h4;
   localparam logic [3:0] EMP_WRCNT_OFS  = 4'h8;
   localparam logic [3:0] EMP_CONFIG_OFS = 4'hC;

   // control register: bit 0 lets the input registers run
   localparam int         EMP_CTRL_RUN_BIT = 0;
   localparam logic [0:0] EMP_CTRL_RST     = 1'h1;

   // config register field positions
   localparam int EMP_CFG_IN_CE   = 0;
   localparam int EMP_CFG_OUT_CE  = 1;
   localparam int EMP_CFG_HOLD    = 2;
   localparam int EMP_CFG_ACLR    = 3;
   localparam int EMP_CFG_CLR_QA  = 4;
   localparam int EMP_CFG_CLR_QB  = 5;
   localparam int EMP_CFG_REG_Q   = 6;
   localparam int EMP_CFG_RD_EN   = 7;
   localparam int EMP_CFG_INIT_B  = 8;
   localparam int EMP_CFG_MODE_LO = 9;

   localparam int EMP_BUS_W = 32;

endpackage

// file: core/emp_mem_if.sv
`timescale 1ns/100ps
interface emp_mem_if #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 8,
   parameter int LANES  = 1
);
   logic              rst_n;
   logic              clr;
   logic              ce;
   logic              we;
   logic              rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [LANES-1:0]  lane_en;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output rst_n, clr, ce, we, rd, addr, wdata, lane_en, input rdata);
   modport mem  (input rst_n, clr, ce, we, rd, addr, wdata, lane_en, output rdata);
endinterface

// file: core/emp_mem_array.sv
`timescale 1ns/100ps
module emp_mem_array #(
   parameter int                  DATA_W     = 8,
   parameter int                  ADDR_W     = 8,
   parameter int                  DEPTH      = 256,
   parameter int                  LANE_W     = 8,
   parameter logic [DEPTH*DATA_W-1:0] INIT_IMAGE = '0
)(
   input  wire logic  clk_i,
   emp_mem_if.mem     m
);
   localparam int LANES = DATA_W / LANE_W;

   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] rdata_q;

   // flat image: same bit order whichever port's words it is cut in
   initial
   begin
      for (int i = 0; i < DEPTH; i++)
         mem_q[i] = INIT_IMAGE[i*DATA_W +: DATA_W];
   end

   always @(posedge clk_i)
   begin
      if (m.ce && m.we)
      begin
         for (int g = 0; g < LANES; g++)
            if (m.lane_en[g])
               mem_q[m.addr][g*LANE_W +: LANE_W] <= m.wdata[g*LANE_W +: LANE_W];
      end
   end

   // read data always leaves from a flop
   always_ff @(posedge clk_i or posedge m.clr)
   begin
      if (m.clr)
         rdata_q <= '0;
      else if (!m.rst_n)
         rdata_q <= '0;
      else if (m.ce && m.rd)
         rdata_q <= mem_q[m.addr];
   end

   assign m.rdata = rdata_q;
endmodule

// file: core/emp_out_stage.sv
`timescale 1ns/100ps
module emp_out_stage #(
   parameter int DATA_W = 8
)(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              clr_i,
   input  wire logic              ce_i,
   input  wire logic [DATA_W-1:0] d_i,
   output logic      [DATA_W-1:0] q_o
);
   logic [DATA_W-1:0] q_q;

   always_ff @(posedge clk_i or posedge clr_i)
   begin
      if (clr_i)
         q_q <= '0;
      else if (!rst_n_i)
         q_q <= '0;
      else if (ce_i)
         q_q <= d_i;
   end

   assign q_o = q_q;
endmodule

// file: bench/emp_user_model.sv
`timescale 1ns/100ps
module emp_user_model #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 4,
   parameter int LANES  = 2
)(
   input  wire logic         clk_i,
   output logic              in_ce_o,
   output logic              out_ce_o,
   output logic              we_o,
   output logic              rd_o,
   output logic              hold_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o,
   output logic [LANES-1:0]  be_o
);
   initial
   begin
      {in_ce_o, out_ce_o, we_o, rd_o, hold_o} = 5'h18;
      addr_o = '0;
      wdata_o = '0;
      be_o = '0;
   end

   // one taken edge per request; idle lines show the inverse so stale values never match
   task automatic op(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] b, input logic h);
      @(posedge clk_i);
      we_o <= w;
      rd_o <= r;
      hold_o <= h;
      addr_o <= a;
      wdata_o <= d;
      be_o <= b;
      @(posedge clk_i);
      we_o <= 1'b0;
      rd_o <= 1'b0;
      hold_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      be_o <= ~b;
   endtask

   // write, then read the same word on the very next edge
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      {we_o, rd_o, hold_o} <= 3'h4;
      addr_o <= a;
      wdata_o <= d;
      be_o <= '1;
      @(posedge clk_i);
      {we_o, rd_o} <= 2'h1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic set_ce(input logic i, input logic o);
      @(posedge clk_i);
      in_ce_o <= i;
      out_ce_o <= o;
   endtask
endmodule

// file: bench/test_embedded_memory_port_a_interface.sv
`timescale 1ns/100ps
module test_embedded_memory_port_a_interface;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        aclr_i = 1'b0;
   logic [3:0]  avs_address_i = 4'h0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        ice, oce, we, rd, hold;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata;
   logic [1:0]  be;
   logic [15:0] last = 16'h0;
   logic [31:0] rv;
   int          err_total = 0;
   int          checked = 0;
   int          cyc = 0;

   always #5 mclk_i = ~mclk_i;

   emp_user_model u_usr (.clk_i(mclk_i), .in_ce_o(ice), .out_ce_o(oce), .we_o(we), .rd_o(rd),
      .hold_o(hold), .addr_o(addr), .wdata_o(wdata), .be_o(be));

   // image supplied by the integrator
   emp_port_a #(.DATA_W(16), .ADDR_W(4), .DEPTH(16), .LANE_W(8),
      .INIT_IMAGE({16{16'h5A3C}})) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .aclr_i(aclr_i), .in_clk_en_a_i(ice),
      .out_clk_en_a_i(oce), .wr_data_a_i(wdata), .addr_a_i(addr), .wr_en_a_i(we),
      .rd_en_a_i(rd), .byte_en_a_i(be), .addr_hold_a_i(hold), .rd_data_a_o(rdata),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge mclk_i);
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic r, input logic h, input logic [15:0] e);
      u_usr.op(1'b0, r, a, 16'h0, 2'h3, h);
      #1;
      chk("rd_data early", {16'h0, rdata}, {16'h0, last});
      @(posedge mclk_i);
      #1;
      chk("rd_data", {16'h0, rdata}, {16'h0, e});
      last = e;
   endtask

   task automatic t_regs();
      av(1'b0, emp_pkg::EMP_CTRL_OFS, 32'h0, rv);
      chk("ctrl", rv, 32'h1);
      av(1'b1, emp_pkg::EMP_CTRL_OFS, 32'h0, rv);
      av(1'b0, emp_pkg::EMP_STATUS_OFS, 32'h0, rv);
      chk("status stopped", rv, 32'h0);
      av(1'b1, emp_pkg::EMP_CTRL_OFS, 32'h1, rv);
      av(1'b0, emp_pkg::EMP_STATUS_OFS, 32'h0, rv);
      chk("status running", rv, 32'h0000_0010);
      av(1'b1, emp_pkg::EMP_CONFIG_OFS, 32'h0, rv);
      av(1'b1, 4'h2, 32'hFFFF_FFFF, rv);
      av(1'b0, emp_pkg::EMP_CONFIG_OFS, 32'h0, rv);
      chk("config", rv, 32'h0000_00DF);
      av(1'b0, 4'h2, 32'h0, rv);
      chk("unmapped", rv, 32'h0);
      chk("width", $bits(dut.rd_data_a_o), $bits(dut.wr_data_a_i));
      $display("test regs done");
   endtask

   task automatic t_data();
      rd_chk(4'h3, 1'b1, 1'b0, 16'h5A3C);
      u_usr.op(1'b1, 1'b0, 4'h5, 16'h1234, 2'h3, 1'b0);
      u_usr.op(1'b0, 1'b0, 4'h5, 16'hDEAD, 2'h3, 1'b0);
      rd_chk(4'h5, 1'b1, 1'b0, 16'h1234);
      u_usr.op(1'b1, 1'b0, 4'h5, 16'hFFFF, 2'h1, 1'b0);
      rd_chk(4'h5, 1'b1, 1'b0, 16'h12FF);
      u_usr.op(1'b1, 1'b0, 4'h6, 16'hBEEF, 2'h3, 1'b0);
      rd_chk(4'h9, 1'b1, 1'b0, 16'h5A3C);
      rd_chk(4'h5, 1'b1, 1'b1, 16'hBEEF);
      rd_chk(4'h3, 1'b0, 1'b0, 16'hBEEF);
      u_usr.wr_rd(4'h8, 16'hC0DE);
      @(posedge mclk_i);
      #1;
      chk("rd_data after write", {16'h0, rdata}, 32'h0000_C0DE);
      last = 16'hC0DE;
      $display("test data done");
   endtask

   task automatic t_ce();
      u_usr.set_ce(1'b0, 1'b1);
      u_usr.op(1'b1, 1'b0, 4'h7, 16'h7777, 2'h3, 1'b0);
      u_usr.set_ce(1'b1, 1'b1);
      rd_chk(4'h7, 1'b1, 1'b0, 16'h5A3C);
      rd_chk(4'h5, 1'b1, 1'b0, 16'h12FF);
      u_usr.set_ce(1'b1, 1'b0);
      rd_chk(4'h3, 1'b1, 1'b0, 16'h12FF);
      last = 16'h5A3C;
      u_usr.set_ce(1'b1, 1'b1);
      @(posedge mclk_i);
      #1;
      chk("rd_data resumed", {16'h0, rdata}, 32'h5A3C);
      @(posedge mclk_i);
      aclr_i <= 1'b1;
      #1;
      chk("rd_data cleared", {16'h0, rdata}, 32'h0);
      @(posedge mclk_i);
      aclr_i <= 1'b0;
      rd_chk(4'h5, 1'b1, 1'b0, 16'h12FF);
      av(1'b0, emp_pkg::EMP_WRCNT_OFS, 32'h0, rv);
      chk("write count", rv, 32'h4);
      $display("test enables done");
   endtask

   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         finish_test();
      end
   end

   initial
   begin
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_data();
      t_ce();
      finish_test();
   end
endmodule
